// File: chipset_wake_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// chipset end of the shared wake line
// ----------------------------------------
module chipset_wake_model (
  input  wire wake_request_out,
  input  wire wake_request_oe,
  input  wire active_high,
  output wire wake_line,
  output wire wake_seen
);
  // board pull-up owns the line whenever the device lets go
  assign wake_line = wake_request_oe ? wake_request_out : 1'b1;
  assign wake_seen = active_high ? wake_line : !wake_line;
endmodule

// File: power_event_wake_aggregator.v
// How it works
// - wake request rises on ring, key/mouse data, key match, irq, watchdog, gpio, fan.
// - wake pin polarity programmable; reset gives active-low open-drain drive.
// - bit 7 of wake pin control picks open-drain or push-pull.
// - global enable low holds the wake request inactive always.
// - global enable high: any enabled source with status set asserts wake.
// - summary status is set by source edges regardless of global enable.
// - summary status is the OR of every status bit ANDed with its enable.
// - summary status stays set until software clears, or disables, every pending enabled status bit.
// - gpio status sets on the edge its polarity selects; rising by default.
// - gpio with either-edge trigger sets status on both edges.
// - gpio status clears only on a written one; zero leaves it.
// - port pin events trigger on falling edge, or both edges via register 21h.
// - in both-edge mode the wake request holds until status is cleared.
// - port pin status clears on written one, also dropping its management interrupt.
// - status and enable registers sit in runtime block at base from 0x60/0x61.
// - pairs 2-5 and 7 gpio, pair 6 device irqs, pair 1 pins/functions.
// - fan tachometer event has a status bit and an enable bit.
// - one scan code at 0x5F, kept in standby domain, reset by standby reset.
// - key match sets status one bit 5; wake only with enable one bit 5.
// - bit 0 of 0xF0 picks external slow clock, else derived internally.
// - bit 1 of 0xF0 set turns the key logic off by blocking its clock.
`timescale 1ns/100ps
`include "wake_agg_map.vh"

module power_event_wake_aggregator (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        standby_por,
  input  wire [7:0]  cfg_addr,
  input  wire        cfg_wr,
  input  wire [7:0]  cfg_wdata,
  output reg  [7:0]  cfg_rdata,
  input  wire [15:0] io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  input  wire        ring_indicator_a,
  input  wire        ring_indicator_b,
  input  wire        kbd_clk_pin,
  input  wire        kbd_data_pin,
  input  wire        mouse_data_pin,
  input  wire        kbd_port_pin_event,
  input  wire        mouse_port_pin_event,
  input  wire [39:0] gpio_in,
  input  wire [39:0] gpio_polarity,
  input  wire [39:0] either_edge_trigger,
  input  wire [7:0]  device_irq,
  input  wire        watchdog_expired,
  input  wire        fan_tach_event,
  input  wire        ext_slow_clock,
  output reg         wake_request_out,
  output reg         wake_request_oe,
  output reg         summary_wake_status,
  output reg  [1:0]  port_pin_smi
);

// ----------------------------------------
// helpers
// ----------------------------------------
  // pol=0 rising, pol=1 falling, either overrides both
  function edge_hit;
    input prev;
    input cur;
    input pol;
    input either;
    begin
      if (either)
        edge_hit = prev ^ cur;
      else if (pol)
        edge_hit = prev & ~cur;
      else
        edge_hit = ~prev & cur;
    end
  endfunction

  function [7:0] byte_of;
    input [63:0] flat;
    input [2:0]  idx;
    begin
      byte_of = flat[idx*8 +: 8];
    end
  endfunction

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
  reg  [47:0] pin_meta;
  reg  [47:0] pin_sync;
  reg  [47:0] pin_prev;
  wire [47:0] pin_raw = {ring_indicator_a, ring_indicator_b, kbd_data_pin,
                         mouse_data_pin, kbd_port_pin_event,
                         mouse_port_pin_event, gpio_in, ext_slow_clock,
                         kbd_clk_pin};

  always @(posedge ref_clk) begin
    pin_meta <= pin_raw;
    pin_sync <= pin_meta;
    pin_prev <= pin_sync;
  end

  wire [39:0] gpio_s     = pin_sync[41:2];
  wire [39:0] gpio_p     = pin_prev[41:2];
  wire        ext_clk_s  = pin_sync[1];
  wire        ext_clk_p  = pin_prev[1];
  wire        kbd_clk_s  = pin_sync[0];

// ----------------------------------------
// internal event edges
// ----------------------------------------
  reg  [7:0] irq_prev;
  reg        wdt_prev;
  reg        fan_prev;

  always @(posedge ref_clk) begin
    if (reset) begin
      irq_prev <= `BYTE_RESET;
      wdt_prev <= 1'b0;
      fan_prev <= 1'b0;
    end else begin
      irq_prev <= device_irq;
      wdt_prev <= watchdog_expired;
      fan_prev <= fan_tach_event;
    end
  end

// ----------------------------------------
// configuration registers
// ----------------------------------------
  reg [7:0] base_hi;
  reg [7:0] base_lo;
  reg [7:0] slow_clock_config;

  always @(posedge ref_clk) begin
    if (reset) begin
      base_hi           <= `BYTE_RESET;
      base_lo           <= `BYTE_RESET;
      slow_clock_config <= `CFG_SLOW_RESET;
      cfg_rdata         <= `BYTE_RESET;
    end else begin
      if (cfg_wr) begin
        if (cfg_addr == `CFG_BASE_HI)
          base_hi <= cfg_wdata;
        else if (cfg_addr == `CFG_BASE_LO)
          base_lo <= cfg_wdata;
        else if (cfg_addr == `CFG_SLOW_CLOCK)
          slow_clock_config <= cfg_wdata;
      end
      if (cfg_addr == `CFG_BASE_HI)
        cfg_rdata <= base_hi;
      else if (cfg_addr == `CFG_BASE_LO)
        cfg_rdata <= base_lo;
      else if (cfg_addr == `CFG_SLOW_CLOCK)
        cfg_rdata <= slow_clock_config;
      else
        cfg_rdata <= `BYTE_RESET;
    end
  end

  wire ext_present = slow_clock_config[`SLOW_EXT_BIT];
  wire key_off     = slow_clock_config[`SLOW_OFF_BIT];

// ----------------------------------------
// runtime decode
// ----------------------------------------
  wire [15:0] rt_delta = io_addr - {base_hi, base_lo};
  wire        rt_hit   = (rt_delta < `RT_BLOCK_SIZE);
  wire [7:0]  rt_off   = rt_delta[7:0];
  wire        rt_wr    = io_wr & rt_hit;
  wire        sts_sel  = (rt_off & `RT_PAIR_MASK) == `RT_STS_BASE;
  wire        en_sel   = (rt_off & `RT_PAIR_MASK) == `RT_EN_BASE;
  wire [2:0]  pair_idx = rt_off[2:0];

// ----------------------------------------
// slow clock tick
// ----------------------------------------
  // the internal tick stands in for the derived 32 kHz source; it only
  // exists while this clock runs, so standby wake needs the external clock
  reg  [10:0] slow_div;
  wire        div_end  = (slow_div == `SLOW_DIV_CYCLES - 1);
  wire        ext_tick = ext_clk_s & ~ext_clk_p;
  wire        slow_tick = ~key_off & (ext_present ? ext_tick : div_end);

  always @(posedge ref_clk) begin
    if (reset || key_off || div_end)
      slow_div <= 11'h000;
    else
      slow_div <= slow_div + 11'h001;
  end

// ----------------------------------------
// wake key receiver
// ----------------------------------------
  reg [7:0]  wake_key_scan_code;
  reg [10:0] key_frame;
  reg [3:0]  key_bits;
  reg [7:0]  key_idle;
  reg        key_clk_seen;
  reg        key_match;
  wire       key_fall = slow_tick & key_clk_seen & ~kbd_clk_s;
  wire [10:0] next_frame = {pin_sync[45], key_frame[10:1]};

  always @(posedge ref_clk) begin
    if (standby_por)
      wake_key_scan_code <= `BYTE_RESET;
    else if (rt_wr && rt_off == `RT_SCAN_CODE)
      wake_key_scan_code <= io_wdata;
  end

  always @(posedge ref_clk) begin
    if (reset || key_off) begin
      key_frame    <= 11'h000;
      key_bits     <= 4'h0;
      key_idle     <= `BYTE_RESET;
      key_clk_seen <= 1'b1;
      key_match    <= 1'b0;
    end else begin
      key_match <= 1'b0;
      if (slow_tick)
        key_clk_seen <= kbd_clk_s;
      if (key_fall) begin
        key_idle <= `BYTE_RESET;
        if (key_bits == `KEY_FRAME_BITS - 4'd1) begin
          key_bits  <= 4'h0;
          key_frame <= 11'h000;
          // start low, stop high, odd parity over data and parity
          key_match <= ~next_frame[0] & next_frame[10] & (^next_frame[9:1])
                       & (next_frame[8:1] == wake_key_scan_code);
        end else begin
          key_bits  <= key_bits + 4'd1;
          key_frame <= next_frame;
        end
      end else if (slow_tick) begin
        // a stalled frame is dropped so the next one starts aligned
        if (key_idle == `KEY_IDLE_TICKS) begin
          key_bits  <= 4'h0;
          key_frame <= 11'h000;
        end else begin
          key_idle <= key_idle + 8'h01;
        end
      end
    end
  end

// ----------------------------------------
// event collection
// ----------------------------------------
  reg [7:0] wake_edge_select;
  reg [63:0] set_flat;
  integer    g;

  always @* begin
    set_flat = 64'h0;
    // pair one: pins and internal functions
    set_flat[`RING_A_BIT] = edge_hit(pin_prev[47], pin_sync[47], 1'b1, 1'b0);
    set_flat[`RING_B_BIT] = edge_hit(pin_prev[46], pin_sync[46], 1'b1, 1'b0);
    set_flat[`KBD_DATA_BIT] = edge_hit(pin_prev[45], pin_sync[45], 1'b1, 1'b0);
    set_flat[`MOUSE_DATA_BIT] = edge_hit(pin_prev[44], pin_sync[44], 1'b1, 1'b0);
    set_flat[`WDT_BIT] = watchdog_expired & ~wdt_prev;
    set_flat[`KEY_MATCH_BIT] = key_match;
    set_flat[`FAN_BIT] = fan_tach_event & ~fan_prev;
    // pair six: device interrupts
    set_flat[`PAIR_DEVICE*8 +: 8] = device_irq & ~irq_prev;
    // pairs two to five and seven: gpio
    for (g = 0; g < 40; g = g + 1) begin
      set_flat[((g < `GPIO_LOW_COUNT) ? `GPIO_LOW_BASE + g
                                      : `GPIO_HIGH_BASE + g - `GPIO_LOW_COUNT)] =
        edge_hit(gpio_p[g], gpio_s[g], gpio_polarity[g],
                 either_edge_trigger[g]);
    end
    // pair eight: keyboard and mouse port pins
    set_flat[`PAIR_PORT_PIN*8] =
      edge_hit(pin_prev[43], pin_sync[43], 1'b1,
               wake_edge_select[`EDGE_KBD_BIT]);
    set_flat[`PAIR_PORT_PIN*8 + 1] =
      edge_hit(pin_prev[42], pin_sync[42], 1'b1,
               wake_edge_select[`EDGE_MOUSE_BIT]);
  end

// ----------------------------------------
// status, enable and control registers
// ----------------------------------------
  reg [63:0] sts_flat;
  reg [63:0] en_flat;
  reg [63:0] clr_flat;
  reg        global_wake_enable;
  reg [7:0]  wake_pin_gpio_control;
  integer    p;

  always @* begin
    clr_flat = 64'h0;
    for (p = 0; p < `PAIR_COUNT; p = p + 1) begin
      if (rt_wr && sts_sel && pair_idx == p)
        clr_flat[p*8 +: 8] = io_wdata;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      sts_flat              <= 64'h0;
      en_flat               <= 64'h0;
      global_wake_enable    <= 1'b0;
      wake_edge_select      <= `BYTE_RESET;
      wake_pin_gpio_control <= `BYTE_RESET;
    end else begin
      // a new edge wins over a clear in the same cycle
      sts_flat <= (sts_flat & ~clr_flat) | set_flat;
      if (rt_wr) begin
        if (en_sel)
          en_flat[pair_idx*8 +: 8] <= io_wdata;
        else if (rt_off == `RT_GLOBAL_EN)
          global_wake_enable <= io_wdata[0];
        else if (rt_off == `RT_EDGE_SELECT)
          wake_edge_select <= io_wdata;
        else if (rt_off == `RT_WAKE_PIN_CTRL)
          wake_pin_gpio_control <= io_wdata;
      end
    end
  end

// ----------------------------------------
// register read
// ----------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      io_rdata <= `BYTE_RESET;
    end else if (io_rd) begin
      if (!rt_hit)
        io_rdata <= `BYTE_RESET;
      else if (sts_sel)
        io_rdata <= byte_of(sts_flat, pair_idx);
      else if (en_sel)
        io_rdata <= byte_of(en_flat, pair_idx);
      else if (rt_off == `RT_SUMMARY)
        io_rdata <= {7'h00, summary_wake_status};
      else if (rt_off == `RT_GLOBAL_EN)
        io_rdata <= {7'h00, global_wake_enable};
      else if (rt_off == `RT_EDGE_SELECT)
        io_rdata <= wake_edge_select;
      else if (rt_off == `RT_WAKE_PIN_CTRL)
        io_rdata <= wake_pin_gpio_control;
      else if (rt_off == `RT_SCAN_CODE)
        io_rdata <= wake_key_scan_code;
      else
        io_rdata <= `BYTE_RESET;
    end
  end

// ----------------------------------------
// summary and wake pin
// ----------------------------------------
  // summary is a pure function of the sticky bits and their enables, so it falls
  // once every pending enabled status has been cleared or had its enable written to zero
  wire next_summary = |(sts_flat & en_flat);
  wire wake_active  = global_wake_enable & next_summary;
  wire pin_level    = wake_pin_gpio_control[`PIN_POL_BIT] ? wake_active
                                                          : ~wake_active;
  wire pin_func_on  = ~wake_pin_gpio_control[`PIN_FUNC_OFF_BIT];
  wire push_pull    = wake_pin_gpio_control[`PIN_PUSH_PULL_BIT];
  wire next_oe      = pin_func_on & (push_pull | ~pin_level);
  wire next_out     = push_pull & pin_level;

  always @(posedge ref_clk) begin
    if (reset) begin
      summary_wake_status <= 1'b0;
      wake_request_out    <= 1'b0;
      wake_request_oe     <= 1'b0;
      port_pin_smi        <= 2'b00;
    end else begin
      summary_wake_status <= next_summary;
      wake_request_out    <= next_out;
      wake_request_oe     <= next_oe;
      port_pin_smi        <= sts_flat[`PAIR_PORT_PIN*8 +: 2] & ~clr_flat[`PAIR_PORT_PIN*8 +: 2]
                             | set_flat[`PAIR_PORT_PIN*8 +: 2];
    end
  end

endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg         ref_clk = 1'b0;
  reg         reset = 1'b1;
  reg         standby_por = 1'b1;
  reg  [7:0]  cfg_addr = 8'h00;
  reg         cfg_wr = 1'b0;
  reg  [7:0]  cfg_wdata = 8'h00;
  wire [7:0]  cfg_rdata;
  reg  [15:0] io_addr = 16'h0000;
  reg         io_wr = 1'b0;
  reg         io_rd = 1'b0;
  reg  [7:0]  io_wdata = 8'h00;
  wire [7:0]  io_rdata;
  reg  [7:0]  src = 8'h0F;
  reg  [41:0] lv = 42'h30000000000;
  reg  [39:0] gpio_pol = 40'h0;
  reg  [39:0] gpio_ee = 40'h0;
  reg  [7:0]  device_irq = 8'h00;
  reg         kbd_clk_pin = 1'b1;
  reg         key_data = 1'b1;
  reg         ext_slow_clock = 1'b0;
  reg         ext_run = 1'b0;
  reg         active_high = 1'b0;
  reg         snap = 1'b0;
  reg         rd_q = 1'b0;
  wire        wake_request_out, wake_request_oe, summary_wake_status, wake_line, wake_seen;
  wire [1:0]  port_pin_smi;
  reg  [7:0]  rd_exp[$];
  reg  [4:0]  pin_exp[$];
  reg  [15:0] base = 16'h0000;
  reg  [7:0]  code;
  integer     miscompares = 0;
  integer     samples_checked = 0;
  integer     cycles = 0;
  integer     i;
  integer     b;

  power_event_wake_aggregator power_event_wake_aggregator_inst (
    .ref_clk(ref_clk), .reset(reset), .standby_por(standby_por), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .ring_indicator_a(src[0]), .ring_indicator_b(src[1]), .kbd_clk_pin(kbd_clk_pin),
    .kbd_data_pin(src[2] & key_data), .mouse_data_pin(src[3]),
    .kbd_port_pin_event(lv[40]), .mouse_port_pin_event(lv[41]), .gpio_in(lv[39:0]),
    .gpio_polarity(gpio_pol), .either_edge_trigger(gpio_ee), .device_irq(device_irq),
    .watchdog_expired(src[4]), .fan_tach_event(src[6]), .ext_slow_clock(ext_slow_clock),
    .wake_request_out(wake_request_out), .wake_request_oe(wake_request_oe),
    .summary_wake_status(summary_wake_status), .port_pin_smi(port_pin_smi));
  chipset_wake_model chipset_wake_model_inst (
    .wake_request_out(wake_request_out), .wake_request_oe(wake_request_oe),
    .active_high(active_high), .wake_line(wake_line), .wake_seen(wake_seen));

  always #10 ref_clk = ~ref_clk;
  // odd half period keeps the slow clock out of phase with ref_clk
  always #163 if (ext_run) ext_slow_clock = ~ext_slow_clock;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task check(input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      if (miscompares == 0 && samples_checked > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    if (rd_q) check(io_rdata, rd_exp.pop_front());
    if (snap) check({3'h0, wake_request_oe, wake_seen, summary_wake_status, port_pin_smi},
      {3'h0, pin_exp.pop_front()});
    rd_q <= io_rd;
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
    end
  endtask
  task wr(input [7:0] off, input [7:0] d);
    begin
      @(posedge ref_clk);
      io_addr <= base + off;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge ref_clk);
      io_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] off, input [7:0] e);
    begin
      rd_exp.push_back(e);
      @(posedge ref_clk);
      io_addr <= base + off;
      io_rd <= 1'b1;
      @(posedge ref_clk);
      io_rd <= 1'b0;
    end
  endtask
  task pin(input [4:0] e);
    begin
      pin_exp.push_back(e);
      tick(2);
      snap <= 1'b1;
      @(posedge ref_clk);
      snap <= 1'b0;
    end
  endtask
  task cfg(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_wr <= 1'b1;
      @(posedge ref_clk);
      cfg_wr <= 1'b0;
      tick(2);
    end
  endtask
  task ev(input integer n);
    begin
      @(posedge ref_clk);
      src[n] <= ~src[n];
      tick(8);
      src[n] <= ~src[n];
      tick(8);
    end
  endtask
  task put(input integer n, input v);
    begin
      @(posedge ref_clk);
      lv[n] <= v;
      tick(8);
    end
  endtask
  // keyboard side: start 0, data lsb first, parity, stop 1; data moves while clock high
  // h is the half period of the keyboard clock in ref_clk cycles; it must
  // exceed the slow tick spacing so that each clock phase is sampled
  task key(input [7:0] c, input p, input integer h);
    reg [10:0] f;
    integer    j;
    begin
      f = {1'b1, p, c, 1'b0};
      for (j = 0; j < 11; j = j + 1) begin
        @(posedge ref_clk);
        key_data <= f[j];
        tick(h);
        kbd_clk_pin <= 1'b0;
        tick(h);
        kbd_clk_pin <= 1'b1;
      end
      tick(1100);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    code = $urandom(32'h03F2);
    tick(6);
    reset <= 1'b0;
    standby_por <= 1'b0;
    tick(2);
    for (i = 0; i < 16; i = i + 1) rd(8'h10 + i, 8'h00);
    rd(8'h5F, 8'h00);
    cfg(8'h60, 8'h0A);
    cfg(8'h61, 8'h00);
    base = 16'h0A00;
    rd(8'hFF, 8'h00);
    wr(8'h18, 8'h7F);
    ev(4);
    rd(8'h10, 8'h10);
    rd(8'h00, 8'h01);
    pin(5'b00100);
    wr(8'h18, 8'h00);
    pin(5'b00000);
    wr(8'h18, 8'h7F);
    wr(8'h10, 8'h00);
    rd(8'h10, 8'h10);
    wr(8'h10, 8'h10);
    pin(5'b00000);
    wr(8'h01, 8'h01);
    for (i = 0; i < 7; i = i + 1) if (i != 5) begin
      ev(i);
      rd(8'h10, 8'h01 << i);
      pin(5'b11100);
      wr(8'h10, 8'h01 << i);
      pin(5'b00000);
    end
    ev(0);
    ev(6);
    wr(8'h10, 8'h01);
    pin(5'b11100);
    wr(8'h10, 8'h40);
    wr(8'h19, 8'hFF);
    wr(8'h1E, 8'hFF);
    gpio_pol[1] <= 1'b1;
    gpio_ee[2] <= 1'b1;
    put(0, 1'b1);
    rd(8'h11, 8'h01);
    wr(8'h11, 8'hFF);
    put(0, 1'b0);
    put(1, 1'b1);
    rd(8'h11, 8'h00);
    put(1, 1'b0);
    rd(8'h11, 8'h02);
    wr(8'h11, 8'hFF);
    put(2, 1'b1);
    rd(8'h11, 8'h04);
    wr(8'h11, 8'hFF);
    put(2, 1'b0);
    rd(8'h11, 8'h04);
    wr(8'h11, 8'hFF);
    put(32, 1'b1);
    rd(8'h16, 8'h01);
    pin(5'b11100);
    wr(8'h16, 8'h01);
    b = $urandom % 8;
    wr(8'h1D, 8'hFF);
    @(posedge ref_clk);
    device_irq[b] <= 1'b1;
    tick(4);
    device_irq[b] <= 1'b0;
    rd(8'h15, 8'h01 << b);
    wr(8'h15, 8'hFF);
    wr(8'h1F, 8'h03);
    put(40, 1'b0);
    rd(8'h17, 8'h01);
    pin(5'b11101);
    put(40, 1'b1);
    rd(8'h17, 8'h01);
    wr(8'h17, 8'h01);
    pin(5'b00000);
    wr(8'h21, 8'h03);
    put(41, 1'b0);
    wr(8'h17, 8'h02);
    put(41, 1'b1);
    rd(8'h17, 8'h02);
    pin(5'b11110);
    wr(8'h17, 8'h02);
    pin(5'b00000);
    put(40, 1'b0);
    wr(8'h17, 8'h01);
    put(40, 1'b1);
    rd(8'h17, 8'h01);
    wr(8'h17, 8'h01);
    ev(0);
    wr(8'h30, 8'h80);
    pin(5'b11100);
    active_high <= 1'b1;
    wr(8'h30, 8'h82);
    pin(5'b11100);
    wr(8'h10, 8'h01);
    pin(5'b10000);
    wr(8'h30, 8'h00);
    active_high <= 1'b0;
    wr(8'h5F, code);
    @(posedge ref_clk);
    reset <= 1'b1;
    tick(3);
    reset <= 1'b0;
    base = 16'h0000;
    rd(8'h5F, code);
    wr(8'h01, 8'h01);
    wr(8'h18, 8'h20);
    key(code, ~^code, 1600);
    rd(8'h10, 8'h24);
    wr(8'h10, 8'hFF);
    cfg(8'hF0, 8'h01);
    ext_run <= 1'b1;
    key(code, ~^code, 64);
    rd(8'h10, 8'h24);
    pin(5'b11100);
    wr(8'h10, 8'hFF);
    key(code ^ 8'h01, ^code, 64);
    rd(8'h10, 8'h04);
    wr(8'h10, 8'hFF);
    key(code, ^code, 64);
    rd(8'h10, 8'h04);
    wr(8'h10, 8'hFF);
    cfg(8'hF0, 8'h03);
    key(code, ~^code, 64);
    rd(8'h10, 8'h04);
    tick(4);
    finish_test;
  end
endmodule

// File: wake_agg_assertions.sv
`timescale 1ns/100ps
module wake_agg_assertions (
  input wire        ref_clk,
  input wire        reset,
  input wire [7:0]  cfg_addr,
  input wire        cfg_wr,
  input wire [7:0]  cfg_wdata,
  input wire [7:0]  cfg_rdata,
  input wire [15:0] io_addr,
  input wire        io_wr,
  input wire        io_rd,
  input wire [7:0]  io_wdata,
  input wire [7:0]  io_rdata,
  input wire        wake_request_out,
  input wire        wake_request_oe,
  input wire        summary_wake_status,
  input wire [1:0]  port_pin_smi
);
  // ----------------------------------------
  // shadow of base, global enable and pin control
  // ----------------------------------------
  reg  [15:0] base;
  reg         gen;
  reg  [7:0]  ctl;
  wire [15:0] off = io_addr - base;
  always @(posedge ref_clk) begin
    if (reset) begin
      base <= 16'h0000;
      gen  <= 1'b0;
      ctl  <= 8'h00;
    end else begin
      if (cfg_wr && cfg_addr == 8'h60) base[15:8] <= cfg_wdata;
      if (cfg_wr && cfg_addr == 8'h61) base[7:0] <= cfg_wdata;
      if (io_wr && off == 16'h0001) gen <= io_wdata[0];
      if (io_wr && off == 16'h0030) ctl <= io_wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  reset_release_a: assert property ($fell(reset) |-> !wake_request_oe && !wake_request_out)
    else $error("wake pin not released after reset");
  wake_gated_a: assert property (!gen && !$past(gen) && !$past(gen, 2) && ctl == 8'h00 &&
    $past(ctl) == 8'h00 |-> !wake_request_oe) else $error("wake driven while disabled");
  wake_follows_a: assert property ((gen && ctl == 8'h00 && summary_wake_status) [*3]
    |-> wake_request_oe && !wake_request_out) else $error("enabled event gave no wake");
  wake_cause_a: assert property ($rose(wake_request_oe) && ctl == 8'h00
    |-> $past(gen) && summary_wake_status) else $error("wake without pending event");
  summary_hold_a: assert property ($fell(summary_wake_status)
    |-> $past(io_wr) || $past(io_wr, 2) || $past(io_wr, 3)) else $error("summary fell alone");
  open_drain_a: assert property (!ctl[7] && !$past(ctl[7]) && wake_request_oe
    |-> !wake_request_out) else $error("open-drain pin driven high");
  smi_clear_a: assert property (io_wr && off == 16'h0017 && io_wdata[1]
    |-> ##[1:2] !port_pin_smi[1]) else $error("port pin interrupt not dropped");
  cfg_readback_a: assert property (cfg_wr && cfg_addr == 8'hF0 ##1
    cfg_addr == 8'hF0 && !cfg_wr ##1 cfg_addr == 8'hF0
    |-> cfg_rdata[1:0] == $past(cfg_wdata[1:0], 2)) else $error("slow clock config lost");
  unmapped_read_a: assert property (io_rd && off >= 16'h0080 |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind power_event_wake_aggregator wake_agg_assertions wake_agg_assertions_inst (
  .ref_clk(ref_clk), .reset(reset), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .io_addr(io_addr), .io_wr(io_wr),
  .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .wake_request_out(wake_request_out), .wake_request_oe(wake_request_oe),
  .summary_wake_status(summary_wake_status), .port_pin_smi(port_pin_smi));

// File: wake_agg_map.vh
`ifndef WAKE_AGG_MAP_VH
`define WAKE_AGG_MAP_VH

// ----------------------------------------
// configuration registers
// ----------------------------------------
`define CFG_BASE_HI       8'h60
`define CFG_BASE_LO       8'h61
`define CFG_SLOW_CLOCK    8'hF0
`define CFG_SLOW_RESET    8'h00
`define SLOW_EXT_BIT      0
`define SLOW_OFF_BIT      1

// ----------------------------------------
// runtime block offsets
// ----------------------------------------
`define RT_BLOCK_SIZE     16'h0080
`define RT_SUMMARY        8'h00
`define RT_GLOBAL_EN      8'h01
`define RT_STS_BASE       8'h10
`define RT_EN_BASE        8'h18
`define RT_PAIR_MASK      8'hF8
`define RT_EDGE_SELECT    8'h21
`define RT_WAKE_PIN_CTRL  8'h30
`define RT_SCAN_CODE      8'h5F

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PAIR_COUNT        8
`define EDGE_KBD_BIT      0
`define EDGE_MOUSE_BIT    1
`define PIN_FUNC_OFF_BIT  0
`define PIN_POL_BIT       1
`define PIN_PUSH_PULL_BIT 7
`define BYTE_RESET        8'h00
`define KEY_MATCH_BIT     5
`define PAIR_ONE          0
`define PAIR_DEVICE       5
`define PAIR_PORT_PIN     7
`define RING_A_BIT        0
`define RING_B_BIT        1
`define KBD_DATA_BIT      2
`define MOUSE_DATA_BIT    3
`define WDT_BIT           4
`define FAN_BIT           6
`define GPIO_LOW_COUNT    32
`define GPIO_LOW_BASE     8
`define GPIO_HIGH_BASE    48

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS     20
`define SLOW_PERIOD_NS    30518
`define SLOW_DIV_CYCLES   (`SLOW_PERIOD_NS / `CLK_PERIOD_NS)
`define KEY_FRAME_BITS    4'd11
`define KEY_IDLE_TICKS    8'h40

`endif
